// [src/mrz_pkg.sv]
// Purpose: Shared constants for the first mode register link and its ends
// Assumes: 10 MHz system clock; link clock made by the controller end
// Notes: Operation
// Operation
// - Controller writes full register after every reset; here it writes only when software writes REG_CMD
// - Every address field driven on each write
// - Register write never touches stored data
// - Two register writes spaced by tMRD
// - Other commands wait tMOD after register write
// - Register write only while memory idle
// - Termination enabled: ODT low until tMOD passes
// - Termination disabled: ODT level is free
// - All select lines and banks low selects register
// - Reserved bank and high address bits zero
// - Bit three picks sequential or interleaved order
// - Two low bits: chop, eight, or per-command
// - Eight-beat read order from starting column
// - Chop read: four beats then outputs off
// - Writes ignore low column bits
// - Fixed chop moves write timing two clocks earlier
// - Whole-cycle CAS latency; read at AL plus CL
// - Test bit kept at zero
// - DLL reset bit clears itself when done
// - Wait tDLLK after DLL reset before reads
// - Write recovery field at least tWR in cycles
// - Bit twelve picks slow or fast power-down exit
// - DLL reset is a write with bit eight high
package mrz_pkg;
  localparam int MR_W = 16;
  localparam int BA_W = 3;
  // Field positions within the register image
  localparam int BL_LSB = 0;
  localparam int BT_BIT = 3;
  localparam int CL_LSB = 4;
  localparam int TM_BIT = 7;
  localparam int DLL_BIT = 8;
  localparam int WR_LSB = 9;
  localparam int PPD_BIT = 12;
  localparam int OTF_BIT = 12;
  // Burst length codes
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIX4 = 2'h2;
  // Latency code plus this base gives whole cycles
  localparam logic [4:0] CL_BASE = 5'h04;
  // Command codes on ras_n, cas_n, we_n
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_NOP = 3'h7;
  // Link timing
  localparam int SYS_NS = 100;
  localparam int LINK_NS = 800;
  localparam int DIV_HALF = LINK_NS / (2 * SYS_NS);
  localparam int T_MRD_CK = 4;
  localparam int T_MOD_CK = 12;
  localparam int T_DLLK_CK = 512;
  localparam int DLL_RST_CK = 8;
  // Register offsets and status bits
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam int ST_BUSY = 0;
  localparam int ST_MRD_OK = 1;
  localparam int ST_MOD_DONE = 2;
  localparam int ST_REFUSED = 3;
  localparam int ST_DLL_WAIT = 4;
  localparam int CT_ODT = 0;
  localparam int CT_RTT = 1;
endpackage : mrz_pkg

// [src/mrz_link_if.sv]
// Purpose: Command, address and clock pins between controller and memory
// Assumes: One-way link, controller drives every pin
// Notes: No clocking block; both ends sample with their own clock
`timescale 1ns/1ns
interface mrz_link_if;
  logic ck;
  logic cke;
  logic odt;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [mrz_pkg::BA_W-1:0] ba;
  logic [mrz_pkg::MR_W-1:0] addr;
  modport ctrl (output ck, cke, odt, cs_n, ras_n, cas_n, we_n, ba, addr);
  modport dev (input ck, cke, odt, cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface : mrz_link_if

// [src/mrz_device.sv]
// Purpose: Memory end: decodes and holds the first mode register
// Assumes: Link pins come from another domain and are synchronised here
// Notes: Reports register fields and per-command burst order to the core
`timescale 1ns/1ns
module mrz_device (
  input wire logic SYS_CLK, // System clock
  input wire logic RST, // Synchronous reset, high
  mrz_link_if.dev LINK, // Link from controller
  input wire logic [3:0] ADD_LAT, // Additive latency in cycles
  output logic MR_VALID, // Register written since reset
  output logic [1:0] BURST_MODE, // Burst length code
  output logic INTERLEAVE, // Interleaved order selected
  output logic [2:0] CAS_CODE, // Latency code
  output logic TEST_MODE, // Test bit state
  output logic DLL_RESET, // DLL reset in progress
  output logic [2:0] WR_CODE, // Write recovery code
  output logic PPD_FAST, // Fast power-down exit
  output logic WRITE_EARLY, // Write timing pulled in
  output logic RD_STROBE, // Read command seen, one cycle
  output logic WR_STROBE, // Write command seen, one cycle
  output logic [23:0] BEAT_COL, // Column per beat, beat 0 low
  output logic [7:0] BEAT_EN, // Beat drives or stores data
  output logic [5:0] READ_LAT // Cycles to first read data
);
  // Six strobe and control pins, then bank and address
  localparam int PW = 6 + mrz_pkg::BA_W + mrz_pkg::MR_W;
  localparam int BL_LO = mrz_pkg::BL_LSB;
  localparam int BL_HI = mrz_pkg::BL_LSB + 1;

  typedef struct packed {
    logic [PW-1:0] s1;
    logic [PW-1:0] s2;
    logic [PW-1:0] s3;
    logic ck1;
    logic ck2;
    logic ck3;
    logic ck_lvl;
    logic [15:0] mr;
    logic valid;
    logic dll_rst;
    logic [3:0] dll_cnt;
    logic rd;
    logic wr;
    logic [23:0] col;
    logic [7:0] en;
    logic [5:0] rlat;
  } mrz_dev_st_t;

  mrz_dev_st_t st_ff;
  mrz_dev_st_t nxt_st;

  // Column of one beat for a given start, beat index and order
  function automatic logic [2:0] beat_col(input logic [2:0] s,
                                          input logic [2:0] i,
                                          input logic il);
    logic [1:0] lo;
    lo = s[1:0] + i[1:0];
    if (il)
      beat_col = s ^ i;
    else
      beat_col = {s[2] ^ i[2], lo};
  endfunction : beat_col

  logic [PW-1:0] pins;
  logic rise;
  logic [2:0] cmd;
  logic [2:0] col0;
  logic chop;
  logic [4:0] cl;

  assign pins = {LINK.cke, LINK.odt, LINK.cs_n, LINK.ras_n, LINK.cas_n,
                 LINK.we_n, LINK.ba, LINK.addr};

  // Three-stage synchronisers, edge found once stages two and three agree
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = pins;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.ck1 = LINK.ck;
    nxt_st.ck2 = st_ff.ck1;
    nxt_st.ck3 = st_ff.ck2;
    if (st_ff.ck2 == st_ff.ck3)
      nxt_st.ck_lvl = st_ff.ck3;
    rise = (st_ff.ck2 == st_ff.ck3) && st_ff.ck3 && !st_ff.ck_lvl;
    cmd = st_ff.s3[PW-4 -: 3];
    col0 = st_ff.s3[2:0];
    nxt_st.rd = 1'b0;
    nxt_st.wr = 1'b0;
    // Per-command chop: fixed, or picked by the command's bit twelve
    chop = (st_ff.mr[BL_HI:BL_LO] == mrz_pkg::BL_FIX4) ||
           ((st_ff.mr[BL_HI:BL_LO] == mrz_pkg::BL_OTF) &&
            !st_ff.s3[mrz_pkg::OTF_BIT]);
    cl = mrz_pkg::CL_BASE + {2'h0, st_ff.mr[mrz_pkg::CL_LSB +: 3]};
    if (rise && st_ff.s3[PW-1] && !st_ff.s3[PW-3])
    begin
      // Only the mode register is written; stored data has no path here
      if (cmd == mrz_pkg::CMD_MRS && st_ff.s3[PW-7 -: 3] == 3'h0)
      begin
        nxt_st.mr = st_ff.s3[15:0];
        nxt_st.valid = 1'b1;
        if (st_ff.s3[mrz_pkg::DLL_BIT])
        begin
          nxt_st.dll_rst = 1'b1;
          nxt_st.dll_cnt = 4'(mrz_pkg::DLL_RST_CK);
        end
      end
      else if (cmd == mrz_pkg::CMD_RD)
      begin
        nxt_st.rd = 1'b1;
        nxt_st.rlat = 6'(ADD_LAT) + 6'(cl);
        for (int i = 0; i < 8; i++)
        begin
          nxt_st.col[3*i +: 3] = beat_col(col0, 3'(i),
                                           st_ff.mr[mrz_pkg::BT_BIT]);
          nxt_st.en[i] = !(chop && i >= 4);
        end
      end
      else if (cmd == mrz_pkg::CMD_WR)
      begin
        nxt_st.wr = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
          // Low start bits ignored; chop keeps only the half chosen by A2
          nxt_st.col[3*i +: 3] = chop ? {col0[2], 2'(i)} : 3'(i);
          nxt_st.en[i] = !(chop && i >= 4);
        end
      end
    end
    // DLL reset bit drops back to zero after the reset has run
    if (rise && st_ff.dll_rst)
    begin
      nxt_st.dll_cnt = st_ff.dll_cnt - 4'h1;
      if (st_ff.dll_cnt == 4'h1)
        nxt_st.dll_rst = 1'b0;
    end
  end

  // State register
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // Outputs come straight from the state register
  assign MR_VALID = st_ff.valid;
  assign BURST_MODE = st_ff.mr[BL_HI:BL_LO];
  assign INTERLEAVE = st_ff.mr[mrz_pkg::BT_BIT];
  assign CAS_CODE = st_ff.mr[mrz_pkg::CL_LSB +: 3];
  assign TEST_MODE = st_ff.mr[mrz_pkg::TM_BIT];
  assign DLL_RESET = st_ff.dll_rst;
  assign WR_CODE = st_ff.mr[mrz_pkg::WR_LSB +: 3];
  assign PPD_FAST = st_ff.mr[mrz_pkg::PPD_BIT];
  // Only fixed chop pulls the internal write in; per-command chop does not
  assign WRITE_EARLY = (st_ff.mr[BL_HI:BL_LO] == mrz_pkg::BL_FIX4);
  assign RD_STROBE = st_ff.rd;
  assign WR_STROBE = st_ff.wr;
  assign BEAT_COL = st_ff.col;
  assign BEAT_EN = st_ff.en;
  assign READ_LAT = st_ff.rlat;
endmodule : mrz_device

// [src/mrz_ctrl.sv]
// Purpose: Controller end: issues first mode register writes for software
// Assumes: Classic Wishbone slave; link clock divided from system clock
// Notes: Commands change on link falling edges, sampled on rising edges
`timescale 1ns/1ns
module mrz_ctrl (
  input wire logic SYS_CLK, // System clock
  input wire logic RST, // Synchronous reset, high
  input wire logic WB_CYC_I, // Bus cycle
  input wire logic WB_STB_I, // Bus strobe
  input wire logic WB_WE_I, // Write enable
  input wire logic [7:0] WB_ADR_I, // Byte address
  input wire logic [3:0] WB_SEL_I, // Byte lanes
  input wire logic [31:0] WB_DAT_I, // Write data
  output logic [31:0] WB_DAT_O, // Read data
  output logic WB_ACK_O, // Acknowledge
  input wire logic DRAM_IDLE, // Banks precharged, bursts done
  mrz_link_if.ctrl LINK // Link to memory
);
  typedef enum logic [1:0] {
    C_IDLE = 2'b00,
    C_ARM = 2'b01,
    C_WAIT = 2'b10
  } mrz_cst_t;

  typedef struct packed {
    mrz_cst_t state;
    logic [2:0] div;
    logic ck;
    logic cke;
    logic odt;
    logic cs_n;
    logic [2:0] cmd;
    logic [2:0] ba;
    logic [15:0] addr;
    logic seen;
    logic [4:0] cnt;
    logic [9:0] dll_cnt;
    logic [15:0] image;
    logic odt_req;
    logic rtt_en;
    logic refused;
    logic ack;
    logic [31:0] dat;
  } mrz_ctrl_st_t;

  mrz_ctrl_st_t st_ff;
  mrz_ctrl_st_t nxt_st;

  logic tog;
  logic rise;
  logic fall;
  logic mrd_ok;
  logic wr_cmd;
  logic [31:0] stat;

  always_comb
  begin
    nxt_st = st_ff;
    // Link clock divider
    tog = (st_ff.div == 3'(mrz_pkg::DIV_HALF - 1));
    nxt_st.div = tog ? 3'h0 : st_ff.div + 3'h1;
    nxt_st.ck = tog ? !st_ff.ck : st_ff.ck;
    rise = tog && !st_ff.ck;
    fall = tog && st_ff.ck;
    nxt_st.cke = 1'b1;
    mrd_ok = (st_ff.state == C_WAIT) &&
             (st_ff.cnt >= 5'(mrz_pkg::T_MRD_CK));
    stat = '0;
    stat[mrz_pkg::ST_BUSY] = (st_ff.state != C_IDLE);
    stat[mrz_pkg::ST_MRD_OK] = mrd_ok || (st_ff.state == C_IDLE);
    stat[mrz_pkg::ST_MOD_DONE] = (st_ff.state == C_IDLE);
    stat[mrz_pkg::ST_REFUSED] = st_ff.refused;
    stat[mrz_pkg::ST_DLL_WAIT] = (st_ff.dll_cnt != 10'h0);
    // Bus slave: one wait state, ack lasts one cycle
    nxt_st.ack = WB_CYC_I && WB_STB_I && !st_ff.ack;
    wr_cmd = nxt_st.ack && WB_WE_I && (WB_ADR_I == mrz_pkg::REG_CMD) &&
             (WB_SEL_I[1:0] == 2'h3);
    if (nxt_st.ack && !WB_WE_I)
    begin
      if (WB_ADR_I == mrz_pkg::REG_STAT)
        nxt_st.dat = stat;
      else if (WB_ADR_I == mrz_pkg::REG_CTRL)
        nxt_st.dat = {30'h0, st_ff.rtt_en, st_ff.odt_req};
      else
        nxt_st.dat = 32'h0;
    end
    if (nxt_st.ack && WB_WE_I && WB_SEL_I[0])
    begin
      if (WB_ADR_I == mrz_pkg::REG_CTRL)
      begin
        nxt_st.odt_req = WB_DAT_I[mrz_pkg::CT_ODT];
        nxt_st.rtt_en = WB_DAT_I[mrz_pkg::CT_RTT];
      end
      if (WB_ADR_I == mrz_pkg::REG_STAT && WB_DAT_I[mrz_pkg::ST_REFUSED])
        nxt_st.refused = 1'b0;
    end
    // Accept a new write only with spacing met and memory idle
    if (wr_cmd)
    begin
      if ((st_ff.state == C_IDLE || mrd_ok) && DRAM_IDLE)
      begin
        nxt_st.image = WB_DAT_I[15:0];
        nxt_st.state = C_ARM;
        nxt_st.seen = 1'b0;
      end
      else
        nxt_st.refused = 1'b1; // Set wins over a same-cycle clear
    end
    // Sequencer; the arm state lets ODT be sampled low at least once
    unique case (st_ff.state)
      C_IDLE:
      begin
      end
      C_ARM:
      begin
        if (rise)
          nxt_st.seen = 1'b1;
        if (fall && st_ff.seen)
        begin
          nxt_st.cs_n = 1'b0;
          nxt_st.cmd = mrz_pkg::CMD_MRS;
          nxt_st.ba = 3'h0;
          // Reserved high bits and test bit forced to zero
          nxt_st.addr = {3'h0, st_ff.image[12:8], 1'b0,
                         st_ff.image[6:0]};
          nxt_st.cnt = 5'h0;
          nxt_st.state = C_WAIT;
          if (st_ff.image[mrz_pkg::DLL_BIT])
            nxt_st.dll_cnt = 10'(mrz_pkg::T_DLLK_CK);
        end
      end
      C_WAIT:
      begin
        if (fall)
        begin
          nxt_st.cs_n = 1'b1;
          nxt_st.cmd = mrz_pkg::CMD_NOP;
        end
        if (rise && st_ff.cnt < 5'(mrz_pkg::T_MOD_CK))
          nxt_st.cnt = st_ff.cnt + 5'h1;
        if (st_ff.cnt >= 5'(mrz_pkg::T_MOD_CK) && !wr_cmd)
          nxt_st.state = C_IDLE;
      end
      default:
        nxt_st.state = C_IDLE;
    endcase
    if (rise && st_ff.dll_cnt != 10'h0 && st_ff.state != C_ARM)
      nxt_st.dll_cnt = st_ff.dll_cnt - 10'h1;
    // With termination on, ODT held low from accept until tMOD passes
    nxt_st.odt = nxt_st.odt_req &&
                 !(nxt_st.rtt_en && nxt_st.state != C_IDLE);
  end

  // State register; link idles deselected after reset
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      st_ff <= '0;
      st_ff.cs_n <= 1'b1;
      st_ff.cmd <= mrz_pkg::CMD_NOP;
    end
    else
      st_ff <= nxt_st;
  end

  assign WB_DAT_O = st_ff.dat;
  assign WB_ACK_O = st_ff.ack;
  assign LINK.ck = st_ff.ck;
  assign LINK.cke = st_ff.cke;
  assign LINK.odt = st_ff.odt;
  assign LINK.cs_n = st_ff.cs_n;
  assign LINK.ras_n = st_ff.cmd[2];
  assign LINK.cas_n = st_ff.cmd[1];
  assign LINK.we_n = st_ff.cmd[0];
  assign LINK.ba = st_ff.ba;
  assign LINK.addr = st_ff.addr;
endmodule : mrz_ctrl

// [tb/mrz_link_props.sv]
// Purpose: Timing and framing checks on the controller-to-memory link
// Assumes: Controller end drives every pin from system-clock flops
// Notes: Link clock rises are counted since the last register write
`timescale 1ns/1ns
module mrz_link_props (
  input wire logic SYS_CLK, // System clock
  input wire logic RST, // Synchronous reset, high
  input wire logic ck, // Link clock
  input wire logic cke, // Clock enable
  input wire logic odt, // Termination request
  input wire logic cs_n, // Chip select, low
  input wire logic ras_n, // Row strobe, low
  input wire logic cas_n, // Column strobe, low
  input wire logic we_n, // Write enable, low
  input wire logic [mrz_pkg::BA_W-1:0] ba, // Bank select
  input wire logic [mrz_pkg::MR_W-1:0] addr // Address
);
  logic ck_q_ff;
  logic seen_ff;
  logic [4:0] rises_ff;
  logic mrs;
  logic ck_rise;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  // Decode of a selected register write and of a sampled clock rise
  assign mrs = !cs_n && !ras_n && !cas_n && !we_n;
  assign ck_rise = ck && !ck_q_ff;
  // Saturating count, so a long idle spell never wraps into a false gap
  always_ff @(posedge SYS_CLK)
  begin
    ck_q_ff <= RST ? 1'h0 : ck;
    seen_ff <= RST ? 1'h0 : (seen_ff | (mrs & ck_rise));
    if (RST || (mrs && ck_rise))
      rises_ff <= 5'h00;
    else if (ck_rise && rises_ff != 5'h1f)
      rises_ff <= rises_ff + 5'h01;
  end
  sequence s_frame;
    !cs_n[*8] ##1 cs_n;
  endsequence
  sequence s_ck_high;
    ck[*4] ##1 !ck;
  endsequence
  AST_RSVD_ZERO: assert property (mrs |-> addr[15:13] == 3'h0)
    else $error("reserved address bits set on register write");
  AST_BANK_ZERO: assert property (mrs |-> ba == 3'h0)
    else $error("bank lines not zero on register write");
  AST_TEST_ZERO: assert property (mrs |-> !addr[7])
    else $error("test bit set on register write");
  AST_CKE_UP: assert property (mrs |-> cke)
    else $error("register write with clock enable low");
  AST_ONLY_MRS: assert property (!cs_n |-> mrs)
    else $error("command other than register write issued");
  AST_FRAME: assert property ($fell(cs_n) |-> s_frame)
    else $error("command not held for one link period");
  AST_STABLE: assert property ($rose(ck) |-> $stable(addr) && $stable(cs_n))
    else $error("command pins moved at link clock rise");
  AST_CK_SHAPE: assert property ($rose(ck) |-> s_ck_high)
    else $error("link clock high phase wrong");
  AST_MRD_GAP: assert property (mrs && ck_rise && seen_ff |->
    rises_ff >= 5'h03)
    else $error("register writes closer than tMRD");
  AST_ODT_HOLD: assert property ($rose(odt) && seen_ff |->
    rises_ff >= 5'h0b)
    else $error("termination raised before tMOD");
endmodule : mrz_link_props

// [tb/testbench.sv]
// Purpose: Drives both ends; a second memory end gets hand-made commands
// Assumes: 10 MHz clock, link period of eight system clocks
// Notes: Register fields are packed into one word per memory end
`timescale 1ns/1ns
module testbench;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic wb_cyc = 1'h0;
  logic wb_stb = 1'h0;
  logic wb_we = 1'h0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic wb_ack;
  logic idle = 1'h1;
  logic [3:0] add_lat = 4'h3;
  wire logic [13:0] f1;
  wire logic [13:0] f2;
  logic rd2;
  logic wr2;
  int rd_n = 0;
  int wr_n = 0;
  logic [23:0] col2;
  logic [23:0] e;
  logic [7:0] en2;
  logic [5:0] lat2;
  logic dll_seen = 1'h0;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  mrz_link_if lk();
  mrz_link_if lk2();
  mrz_ctrl mrz_ctrl_inst (.SYS_CLK(sys_clk), .RST(rst), .WB_CYC_I(wb_cyc),
    .WB_STB_I(wb_stb), .WB_WE_I(wb_we), .WB_ADR_I(wb_adr), .WB_SEL_I(4'hf),
    .WB_DAT_I(wb_dat), .WB_DAT_O(rdat), .WB_ACK_O(wb_ack), .DRAM_IDLE(idle),
    .LINK(lk));
  mrz_device mrz_device_inst (.SYS_CLK(sys_clk), .RST(rst), .LINK(lk),
    .ADD_LAT(add_lat), .MR_VALID(f1[13]), .BURST_MODE(f1[12:11]),
    .INTERLEAVE(f1[10]), .CAS_CODE(f1[9:7]), .TEST_MODE(f1[6]),
    .DLL_RESET(f1[5]), .WR_CODE(f1[4:2]), .PPD_FAST(f1[1]),
    .WRITE_EARLY(f1[0]), .RD_STROBE(), .WR_STROBE(), .BEAT_COL(),
    .BEAT_EN(), .READ_LAT());
  mrz_device mrz_device_inst_b (.SYS_CLK(sys_clk), .RST(rst), .LINK(lk2),
    .ADD_LAT(add_lat), .MR_VALID(f2[13]), .BURST_MODE(f2[12:11]),
    .INTERLEAVE(f2[10]), .CAS_CODE(f2[9:7]), .TEST_MODE(f2[6]),
    .DLL_RESET(f2[5]), .WR_CODE(f2[4:2]), .PPD_FAST(f2[1]),
    .WRITE_EARLY(f2[0]), .RD_STROBE(rd2), .WR_STROBE(wr2), .BEAT_COL(col2),
    .BEAT_EN(en2), .READ_LAT(lat2));
  mrz_link_props mrz_link_props_inst (.SYS_CLK(sys_clk), .RST(rst),
    .ck(lk.ck), .cke(lk.cke), .odt(lk.odt), .cs_n(lk.cs_n),
    .ras_n(lk.ras_n), .cas_n(lk.cas_n), .we_n(lk.we_n), .ba(lk.ba),
    .addr(lk.addr));
  // Clock
  always #50 sys_clk = ~sys_clk;
  // Remembers that the self-clearing reset bit was ever seen high
  always @(posedge sys_clk)
  begin
    if (f1[5] === 1'b1)
      dll_seen <= 1'h1;
    // Strobes last one cycle, so each pulse is counted once
    if (rd2 === 1'b1)
      rd_n++;
    if (wr2 === 1'b1)
      wr_n++;
  end
  // Cuts a hang short
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] x,
    input logic [31:0] g);
    comparisons++;
    if (g !== x)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  // Classic single cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    // Only the bench timeout ends a wait for ack
    do
    begin
      @(posedge sys_clk);
    end
    while (wb_ack !== 1'b1);
    r = rdat;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    @(posedge sys_clk);
  endtask : wb
  // Polls status until the given bit clears; only the bench timeout bounds it
  task automatic poll(input int b);
    do
    begin
      wb(1'h0, mrz_pkg::REG_STAT, 32'h0, q);
    end
    while (q[b] !== 1'b0);
  endtask : poll
  // One command frame on the hand-driven link; address pins inverted afterwards
  task automatic dcmd(input logic [2:0] c, input logic [2:0] b,
    input logic [15:0] a);
    lk2.cs_n <= 1'h0;
    {lk2.ras_n, lk2.cas_n, lk2.we_n} <= c;
    lk2.ba <= b;
    lk2.addr <= a;
    repeat (4) @(posedge sys_clk);
    lk2.ck <= 1'h1;
    repeat (4) @(posedge sys_clk);
    lk2.ck <= 1'h0;
    lk2.cs_n <= 1'h1;
    lk2.addr <= ~a;
    repeat (8) @(posedge sys_clk);
  endtask : dcmd
  // Expected column of each beat from start column and order
  function automatic logic [23:0] ord(input logic [2:0] s, input logic il);
    logic [23:0] r;
    logic [2:0] c;
    for (int i = 0; i < 8; i++)
    begin
      c = 3'(i);
      r[3*i+:3] = il ? (s ^ c) : {s[2] ^ c[2], s[1:0] + c[1:0]};
    end
    return r;
  endfunction : ord
  // Main sequence
  initial
  begin
    lk2.ck = 1'h0;
    lk2.cke = 1'h1;
    lk2.odt = 1'h0;
    lk2.cs_n = 1'h1;
    {lk2.ras_n, lk2.cas_n, lk2.we_n} = 3'h7;
    lk2.ba = 3'h0;
    lk2.addr = 16'h0000;
    repeat (12) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    chk("mr_unset", 32'h0, f1);
    wb(1'h0, 8'h0c, 32'h0, q);
    chk("unmapped", 32'h0, q);
    wb(1'h1, mrz_pkg::REG_CTRL, 32'h3, q);
    wb(1'h1, mrz_pkg::REG_CMD, 32'h9bba, q);
    wb(1'h1, mrz_pkg::REG_CMD, 32'h0, q);
    chk("odt_low", 32'h0, lk.odt);
    poll(0);
    chk("odt_back", 32'h1, lk.odt);
    chk("mr_a", 32'h3597, f1);
    chk("dll_seen", 32'h1, dll_seen);
    chk("st_a", 32'h1e, q[4:0]);
    wb(1'h1, mrz_pkg::REG_STAT, 32'h8, q);
    poll(4);
    chk("st_b", 32'h06, q[4:0]);
    idle <= 1'h0;
    wb(1'h1, mrz_pkg::REG_CMD, 32'h0, q);
    wb(1'h0, mrz_pkg::REG_STAT, 32'h0, q);
    chk("st_c", 32'h0e, q[4:0]);
    chk("mr_b", 32'h3597, f1);
    idle <= 1'h1;
    wb(1'h1, mrz_pkg::REG_STAT, 32'h8, q);
    wb(1'h1, mrz_pkg::REG_CMD, 32'h0, q);
    poll(0);
    chk("mr_c", 32'h2000, f1);
    // Termination off: ODT request passes even while a write is pending
    wb(1'h1, mrz_pkg::REG_CTRL, 32'h1, q);
    wb(1'h1, mrz_pkg::REG_CMD, 32'h0, q);
    chk("odt_free", 32'h1, lk.odt);
    poll(0);
    dcmd(mrz_pkg::CMD_MRS, 3'h0, 16'h0220);
    dcmd(mrz_pkg::CMD_MRS, 3'h1, 16'hffff);
    chk("mr_d", 32'h2104, f2);
    for (int k = 0; k < 16; k++)
    begin
      if (k == 8)
        dcmd(mrz_pkg::CMD_MRS, 3'h0, 16'h0228);
      dcmd(mrz_pkg::CMD_RD, 3'h0, {13'h0000, 3'(k)});
      chk("col8", ord(3'(k), k[3]), col2);
      chk("en8", 32'hff, en2);
    end
    chk("lat", 32'h09, lat2);
    dcmd(mrz_pkg::CMD_MRS, 3'h0, 16'h0222);
    dcmd(mrz_pkg::CMD_RD, 3'h0, 16'h0005);
    e = ord(3'h5, 1'h0);
    chk("col4", e[11:0], col2[11:0]);
    chk("en4", 32'h0f, en2);
    chk("early", 32'h1, f2[0]);
    dcmd(mrz_pkg::CMD_WR, 3'h0, 16'h0006);
    e = ord(3'h4, 1'h0);
    chk("wcol4", e[11:0], col2[11:0]);
    chk("wen4", 32'h0f, en2);
    dcmd(mrz_pkg::CMD_MRS, 3'h0, 16'h0221);
    chk("late", 32'h0, f2[0]);
    dcmd(mrz_pkg::CMD_RD, 3'h0, 16'h1003);
    chk("otf8", 32'hff, en2);
    dcmd(mrz_pkg::CMD_RD, 3'h0, 16'h0003);
    chk("otf4", 32'h0f, en2);
    dcmd(mrz_pkg::CMD_WR, 3'h0, 16'h1005);
    chk("wcol8", ord(3'h0, 1'h0), col2);
    chk("rd_cnt", 32'd19, rd_n);
    chk("wr_cnt", 32'd2, wr_n);
    report_and_stop();
  end
endmodule : testbench
